/* rtl/bsp_pkg.sv */
// Purpose: constants, types, helpers
// Assumes: 100 MHz clock, AXI4-Lite register access, 32-bit words
// Notes: rules below
// Operation
// - receiver deserialises and checks configured format
// - good room: received character enters buffer
// - full buffer: drop, flag overflow, count
// - bad stop bit: store, flag framing, count
// - bad parity: store, flag parity, count
// - receive register read pops buffered character
// - transmit write enqueues, dropped when full
// - transmitter fetches next character after each
// - transmitter serialises with configured format
// - registers show levels, errors; set parameters
// - five to eight data bits selectable
// - one or two stop bits selectable
// - one line standard active at once
package bsp_pkg;
    // clock and default line rate
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_DEF = 115_200;
    localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_DEF);
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_TXLVL = 8'h0c;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_RXLVL = 8'h14;
    localparam logic [7:0] OFS_ERR = 8'h18;
    localparam logic [7:0] OFS_ERRCNT = 8'h1c;
    localparam logic [7:0] OFS_ISTS = 8'h20;
    localparam logic [7:0] OFS_IMASK = 8'h24;
    // control register fields
    localparam int CTRL_DB = 0;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_PAR = 3;
    localparam int CTRL_STD = 5;
    localparam logic [6:0] CTRL_RST = 7'h03;
    // parity codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h2;
    // line standard codes
    localparam logic [1:0] STD_RS485 = 2'h2;
    // error and interrupt bit positions
    localparam int ERR_FRM = 0;
    localparam int ERR_PAR = 1;
    localparam int ERR_OVF = 2;
    localparam int IRQ_RX = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_TX = 2;
    // buffer geometry
    localparam int FIFO_AW = 4;
    localparam logic [FIFO_AW:0] FIFO_DEPTH = 5'h10;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // frame phases, both directions
    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} bsp_ser_e;
    // parity over the active data bits only
    function automatic logic bsp_parity(input logic [7:0] d, input logic [1:0] db,
                                        input logic odd);
        logic [7:0] m;
        m = 8'hff >> (2'h3 - db);
        return (^(d & m)) ^ odd;
    endfunction
endpackage

/* rtl/bsp_rx_if.sv */
// Purpose: receiver line, format and character bundle
// Assumes: line already synchronised to clock
// Notes: valid is a one-cycle pulse per character
interface bsp_rx_if;
    logic line; // synchronised receive level
    logic [15:0] div; // clocks per bit
    logic [1:0] dbits; // data bit code, 0 means five
    logic stop2; // two stop bits
    logic [1:0] par; // parity mode
    logic valid; // character complete
    logic [7:0] data; // received byte, upper bits zero
    logic ferr; // stop bit low
    logic perr; // parity mismatch
    modport rx (input line, div, dbits, stop2, par, output valid, data, ferr, perr);
    modport host (output line, div, dbits, stop2, par, input valid, data, ferr, perr);
endinterface

/* rtl/bsp_rx.sv */
// Purpose: serial to parallel receiver with format checking
// Assumes: div at least 2
// Notes: samples each bit at its middle, found from the start edge
module bsp_rx
    import bsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    bsp_rx_if.rx rif
);
    bsp_ser_e state; // frame phase
    logic [15:0] cnt; // clocks within the bit
    logic [2:0] bitn; // data bit index
    logic [7:0] sh; // assembled byte
    logic perr_q; // parity result held to the end
    logic ferr_q; // any stop bit seen low
    logic stop_seen; // first of two stop bits done
    // mid start bit, then each full bit
    wire tick = (cnt == rif.div - 16'h1);
    wire half = (cnt == {1'b0, rif.div[15:1]});
    wire [2:0] last = {1'b1, rif.dbits} ;
    // shift engine, checks format as it goes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            cnt <= 16'h0;
            bitn <= 3'h0;
            sh <= 8'h0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            stop_seen <= 1'b0;
            rif.valid <= 1'b0;
            rif.data <= 8'h0;
            rif.ferr <= 1'b0;
            rif.perr <= 1'b0;
        end else begin
            rif.valid <= 1'b0;
            cnt <= (tick || state == S_IDLE) ? 16'h0 : cnt + 16'h1;
            unique case (state)
                S_IDLE: begin
                    if (!rif.line) begin
                        state <= S_START;
                        sh <= 8'h0;
                        perr_q <= 1'b0;
                        ferr_q <= 1'b0;
                        stop_seen <= 1'b0;
                    end
                end
                S_START: begin
                    // glitch shorter than half a bit is ignored
                    if (half) begin
                        cnt <= 16'h0;
                        bitn <= 3'h0;
                        state <= rif.line ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    if (tick) begin
                        sh[bitn] <= rif.line;
                        bitn <= bitn + 3'h1;
                        if (bitn == last) begin
                            state <= (rif.par == PAR_NONE) ? S_STOP : S_PAR;
                        end
                    end
                end
                S_PAR: begin
                    if (tick) begin
                        perr_q <= rif.line != bsp_parity(sh, rif.dbits, rif.par == PAR_ODD);
                        state <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (tick) begin
                        if (!rif.line) begin
                            ferr_q <= 1'b1;
                        end
                        if (rif.stop2 && !stop_seen) begin
                            stop_seen <= 1'b1;
                        end else begin
                            // low stop still delivers the byte
                            rif.valid <= 1'b1;
                            rif.data <= sh;
                            rif.ferr <= ferr_q || !rif.line;
                            rif.perr <= perr_q;
                            state <= S_IDLE;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

/* rtl/bsp_top.sv */
// Purpose: buffered serial port with AXI4-Lite registers
// Assumes: one clock, rxd asynchronous to it
// Notes: change format and divider only while the line is quiet
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
module bsp_top
    import bsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxd,
    output logic txd,
    output logic [1:0] line_std,
    output logic line_de,
    output logic irq
);
    // settings
    logic [6:0] ctrl; // data bits, stop, parity, standard
    logic [15:0] div; // clocks per bit
    logic [2:0] err; // sticky error bits
    logic [15:0] err_cnt; // saturating error counter
    logic [2:0] ists; // sticky interrupt status
    logic [2:0] imask; // interrupt enables
    wire [1:0] dbits = ctrl[CTRL_DB +: 2];
    wire stop2 = ctrl[CTRL_STOP];
    wire [1:0] par = ctrl[CTRL_PAR +: 2];

    // rxd synchroniser
    logic rx_meta;
    logic rx_sync;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rxd;
            rx_sync <= rx_meta;
        end
    end

    // receiver
    bsp_rx_if rif ();
    assign rif.line = rx_sync;
    assign rif.div = div;
    assign rif.dbits = dbits;
    assign rif.stop2 = stop2;
    assign rif.par = par;
    bsp_rx u_rx (
        .clock(clock),
        .rst(rst),
        .rif(rif)
    );

    // buffers: memory, pointers and levels
    logic [7:0] rx_mem [FIFO_DEPTH];
    logic [7:0] tx_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] rx_wp, rx_rp, tx_wp, tx_rp;
    logic [FIFO_AW:0] rx_lvl, tx_lvl;
    wire rx_full = (rx_lvl == FIFO_DEPTH);
    wire tx_full = (tx_lvl == FIFO_DEPTH);

    // bus slave state
    logic [7:0] aw_q; // captured write address
    logic [31:0] wd_q; // captured write data
    logic [3:0] ws_q; // captured strobes
    wire do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire lane0 = ws_q[0];
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [7:0] ra = s_axi_araddr[7:0];
    wire ra_hit = (s_axi_araddr[31:8] == 24'h0) && (ra[1:0] == 2'h0) && (ra <= OFS_IMASK);
    wire wa_hit = (aw_q[1:0] == 2'h0) && (aw_q <= OFS_IMASK);

    // side effects of accesses
    wire rx_pop = ar_hs && ra_hit && ra == OFS_RXDATA && rx_lvl != 5'h0;
    wire tx_wr = do_wr && aw_q == OFS_TXDATA && lane0;
    wire tx_push = tx_wr && !tx_full;
    wire rx_push = rif.valid && !rx_full;
    wire rx_ovf = rif.valid && rx_full;
    wire any_err = rx_ovf || (rif.valid && (rif.ferr || rif.perr));
    wire err_wr = do_wr && aw_q == OFS_ERR && lane0;
    wire cnt_wr = do_wr && aw_q == OFS_ERRCNT && lane0;
    wire ists_rd = ar_hs && ra_hit && ra == OFS_ISTS;

    // transmitter state
    bsp_ser_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bitn;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_stop_seen;
    logic tx_done; // one-cycle pulse at end of frame
    wire tx_tick = (tx_cnt == div - 16'h1);
    wire tx_pop = (tx_st == S_IDLE) && (tx_lvl != 5'h0);
    wire [2:0] tx_last = {1'b0, dbits} + 3'h4;

    // read data selection
    logic [31:0] rd_mux;
    assign rd_mux =
        (ra == OFS_CTRL)   ? {25'h0, ctrl} :
        (ra == OFS_DIV)    ? {16'h0, div} :
        (ra == OFS_TXLVL)  ? {27'h0, tx_lvl} :
        (ra == OFS_RXDATA) ? {24'h0, (rx_lvl != 5'h0) ? rx_mem[rx_rp] : 8'h0} :
        (ra == OFS_RXLVL)  ? {27'h0, rx_lvl} :
        (ra == OFS_ERR)    ? {29'h0, err} :
        (ra == OFS_ERRCNT) ? {16'h0, err_cnt} :
        (ra == OFS_ISTS)   ? {29'h0, ists} :
        (ra == OFS_IMASK)  ? {29'h0, imask} : 32'h0;

    // write channel handshakes: address and data in either order
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_q <= 8'h0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_q <= (s_axi_awaddr[31:8] == 24'h0) ? s_axi_awaddr[7:0] : 8'hff;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wa_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= ra_hit ? rd_mux : 32'h0;
            s_axi_rresp <= ra_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // settings registers, written through byte lane 0, the divider also through lane 1
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RST;
            div <= DIV_RST;
            imask <= 3'h0;
        end else if (do_wr) begin
            if (aw_q == OFS_CTRL && lane0) begin
                ctrl <= wd_q[6:0];
            end
            if (aw_q == OFS_DIV) begin
                div[7:0] <= lane0 ? wd_q[7:0] : div[7:0];
                div[15:8] <= ws_q[1] ? wd_q[15:8] : div[15:8];
            end
            if (aw_q == OFS_IMASK && lane0) begin
                imask <= wd_q[2:0];
            end
        end
    end

    // error bits: sticky, write one to clear, a new event wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err <= 3'h0;
            err_cnt <= 16'h0;
        end else begin
            err <= (err & ~(err_wr ? wd_q[2:0] : 3'h0))
                 | {rx_ovf, rif.valid && rif.perr, rif.valid && rif.ferr && !rx_full};
            if (any_err && err_cnt != 16'hffff) begin
                err_cnt <= err_cnt + 16'h1;
            end else if (cnt_wr) begin
                err_cnt <= 16'h0;
            end
        end
    end

    // interrupt status: cleared by reading, new events win
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ists <= 3'h0;
            irq <= 1'b0;
        end else begin
            ists <= (ists_rd ? 3'h0 : ists) | {tx_done, any_err, rx_push};
            irq <= |(ists & imask);
        end
    end

    // receive buffer; bad-format characters are kept as well
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_wp <= '0;
            rx_rp <= '0;
            rx_lvl <= '0;
        end else begin
            if (rx_push) begin
                rx_wp <= rx_wp + 4'h1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 4'h1;
            end
            rx_lvl <= rx_lvl + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end
    always_ff @(posedge clock) begin
        if (rx_push) begin
            rx_mem[rx_wp] <= rif.data;
        end
        if (tx_push) begin
            tx_mem[tx_wp] <= wd_q[7:0];
        end
    end

    // transmit buffer pointers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_wp <= '0;
            tx_rp <= '0;
            tx_lvl <= '0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 4'h1;
            end
            if (tx_pop) begin
                tx_rp <= tx_rp + 4'h1;
            end
            tx_lvl <= tx_lvl + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end

    // transmitter frame sequencing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_st <= S_IDLE;
            tx_cnt <= 16'h0;
            tx_bitn <= 3'h0;
            tx_sh <= 8'h0;
            tx_par <= 1'b0;
            tx_stop_seen <= 1'b0;
            tx_done <= 1'b0;
            txd <= 1'b1;
        end else begin
            tx_done <= 1'b0;
            tx_cnt <= (tx_tick || tx_st == S_IDLE) ? 16'h0 : tx_cnt + 16'h1;
            unique case (tx_st)
                S_IDLE: begin
                    if (tx_pop) begin
                        tx_sh <= tx_mem[tx_rp];
                        tx_par <= bsp_parity(tx_mem[tx_rp], dbits, par == PAR_ODD);
                        tx_bitn <= 3'h0;
                        tx_stop_seen <= 1'b0;
                        txd <= 1'b0;
                        tx_st <= S_START;
                    end
                end
                S_START: begin
                    if (tx_tick) begin
                        txd <= tx_sh[0];
                        tx_st <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tx_tick) begin
                        tx_sh <= tx_sh >> 1;
                        tx_bitn <= tx_bitn + 3'h1;
                        if (tx_bitn == tx_last) begin
                            txd <= (par == PAR_NONE) ? 1'b1 : tx_par;
                            tx_st <= (par == PAR_NONE) ? S_STOP : S_PAR;
                        end else begin
                            txd <= tx_sh[1];
                        end
                    end
                end
                S_PAR: begin
                    if (tx_tick) begin
                        txd <= 1'b1;
                        tx_st <= S_STOP;
                    end
                end
                S_STOP: begin
                    if (tx_tick) begin
                        if (stop2 && !tx_stop_seen) begin
                            tx_stop_seen <= 1'b1;
                        end else begin
                            tx_done <= 1'b1;
                            tx_st <= S_IDLE;
                        end
                    end
                end
                default: tx_st <= S_IDLE;
            endcase
        end
    end

    // one standard at a time; two-wire drives only while sending
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_std <= 2'h0;
            line_de <= 1'b0;
        end else begin
            line_std <= ctrl[CTRL_STD +: 2];
            line_de <= (ctrl[CTRL_STD +: 2] != STD_RS485) || (tx_st != S_IDLE) || tx_pop;
        end
    end
endmodule

/* sim/bsp_chk.sv */
// Purpose: port assertions
// Assumes: one clock domain, rst asynchronous and active high
// Notes: line_de checks wait two samples to allow register lag
module bsp_chk
    import bsp_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic txd,
    input wire logic [1:0] line_std,
    input wire logic line_de,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
        && s_axi_wready) else $error("write response not retired");
    r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not retired");
    ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    // start bit lasts at least two clocks since the divider is at least two
    start_hold_a: assert property ($fell(txd) |-> !txd ##1 !txd)
        else $error("start bit too short");
    de_std_a: assert property ((line_std != STD_RS485) [*2] |-> line_de)
        else $error("driver off on point to point line");
    de_frame_a: assert property ((line_std == STD_RS485 && !txd) [*2] |-> line_de)
        else $error("driver off during two-wire frame");

    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    cover property ($fell(txd) && line_std == STD_RS485);
endmodule

/* sim/bsp_peer.sv */
// Purpose: far-end serial device
// Assumes: bit time equals the divider written by the bench
// Notes: rxd idles high between frames like a real line
module bsp_peer (
    input wire logic clock,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int div = 8; // must match the divider register
    initial rxd = 1'h1; // idle level

    // one bit time on the line
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (div) @(posedge clock);
    endtask

    // one frame, lsb first
    task automatic send(input logic [7:0] d, input int db, input int pm, input int ns,
                        input logic bad_par, input logic bad_stop);
        logic p;
        p = ^(d & (8'hff >> (3 - db))) ^ (pm == 2) ^ bad_par;
        bit_out(1'h0);
        for (int i = 0; i < db + 5; i++) bit_out(d[i]);
        if (pm != 0) bit_out(p);
        for (int i = 0; i < ns; i++) bit_out(!bad_stop);
        bit_out(1'h1); // idle gap
    endtask

    // capture {stop, parity or 1, data}; x on timeout
    task automatic get(output logic [9:0] f, input int db, input int pm);
        int n;
        f = 10'h300;
        for (n = 0; n < 4000 && txd; n++) @(posedge clock);
        repeat (div / 2) @(posedge clock);
        for (int i = 0; i < db + 5; i++) begin
            repeat (div) @(posedge clock);
            f[i] = txd;
        end
        if (pm != 0) begin
            repeat (div) @(posedge clock);
            f[8] = txd;
        end
        repeat (div) @(posedge clock);
        f[9] = txd;
        if (n == 4000) f = 'x;
    endtask
endmodule

/* sim/bsp_tb.sv */
// Purpose: self-checking bench for the buffered serial port
// Assumes: divider set to 8 before any serial traffic
// Notes: register table checks first, then serial and error cases
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb
    import bsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;
        logic [1:0] r;} bsp_row_s;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb = 4'hf; // whole words only
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rxd, txd, line_de, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, line_std, resp;
    int n_fail = 0;
    int num_checks = 0;
    // write/read, address, data, expected read, expected response
    bsp_row_s rows [9] = '{'{1'h0, 32'h0, 32'h0, 32'h3, RESP_OKAY},
        '{1'h0, 32'h4, 32'h0, 32'(DIV_RST), RESP_OKAY}, '{1'h0, 32'h24, 32'h0, 32'h0, RESP_OKAY},
        '{1'h0, 32'h14, 32'h0, 32'h0, RESP_OKAY}, '{1'h0, 32'h28, 32'h0, 32'h0, RESP_SLVERR},
        '{1'h0, 32'h2, 32'h0, 32'h0, RESP_SLVERR}, '{1'h1, 32'h100, 32'h5, 32'h0, RESP_SLVERR},
        '{1'h1, 32'h4, 32'h8, 32'h0, RESP_OKAY}, '{1'h0, 32'h4, 32'h0, 32'h8, RESP_OKAY}};

    bsp_top bsp_top_inst (.*);
    bsp_peer bsp_peer_inst (.clock(clock), .txd(txd), .rxd(rxd));
    always #5 clock = ~clock;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 200 && !s_axi_bvalid; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n == 200) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    // bus read into rd_data and resp
    task automatic rd(input logic [31:0] a);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 200 && !s_axi_rvalid; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        rd_data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n == 200) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic ck(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        `CHK("rdata", e, rd_data)
    endtask

    initial begin
        logic [7:0] m, e;
        logic [9:0] f, g;
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            else ck(rows[i].a, rows[i].e);
            `CHK("resp", rows[i].r, resp)
        end
        // every width, stop count and parity code, both directions
        for (int k = 0; k < 4; k++) begin
            m = 8'hff >> (3 - k);
            wr(OFS_CTRL, 32'({k[1:0], k[0], k[1:0]}));
            bsp_peer_inst.send(8'h5a + 8'(k), k, k, k % 2 + 1, 1'h0, 1'h0);
            ck(OFS_RXDATA, 32'((8'h5a + 8'(k)) & m));
            fork
                bsp_peer_inst.get(f, k, k);
                wr(OFS_TXDATA, 32'(8'hc3 ^ 8'(k)));
            join
            e = (8'hc3 ^ 8'(k)) & m;
            `CHK("frame", {1'h1, (k == 0) ? 1'h1 : (^e ^ (k == 2)), e}, f)
        end
        // back to back characters leave one after the other
        fork
            begin
                bsp_peer_inst.get(f, 3, 3);
                bsp_peer_inst.get(g, 3, 3);
            end
            begin
                wr(OFS_TXDATA, 32'h11);
                wr(OFS_TXDATA, 32'h22);
            end
        join
        `CHK("first", 10'h211, f)
        `CHK("second", 10'h222, g)
        // parity error with the error interrupt unmasked
        wr(OFS_IMASK, 32'h2);
        bsp_peer_inst.send(8'h3c, 3, 3, 2, 1'h1, 1'h0);
        `CHK("irq", 1'h1, irq)
        ck(OFS_ERR, 32'h2);
        ck(OFS_ERRCNT, 32'h1);
        ck(OFS_RXDATA, 32'h3c);
        ck(OFS_ISTS, 32'h7);
        repeat (2) @(posedge clock);
        `CHK("irq", 1'h0, irq)
        bsp_peer_inst.send(8'h77, 3, 3, 2, 1'h0, 1'h0);
        ck(OFS_ERR, 32'h2);
        wr(OFS_ERR, 32'h2);
        ck(OFS_ERR, 32'h0);
        bsp_peer_inst.send(8'h81, 3, 3, 2, 1'h0, 1'h1);
        ck(OFS_ERR, 32'h1);
        ck(OFS_ERRCNT, 32'h2);
        ck(OFS_RXLVL, 32'h2);
        // overflow: two held plus fifteen sent, the last one lost
        wr(OFS_ERR, 32'h7);
        for (int i = 0; i < 15; i++) bsp_peer_inst.send(8'h40 + 8'(i), 3, 3, 2, 1'h0, 1'h0);
        ck(OFS_RXLVL, 32'h10);
        ck(OFS_ERR, 32'h4);
        ck(OFS_ERRCNT, 32'h3);
        for (int i = 0; i < 16; i++) begin
            rd(OFS_RXDATA);
            if (i > 1) `CHK("drain", 32'(i + 62), rd_data)
        end
        ck(OFS_RXDATA, 32'h0);
        // two-wire standard, transmit buffer overrun
        wr(OFS_CTRL, 32'h5f);
        @(posedge clock);
        `CHK("std", STD_RS485, line_std)
        for (int i = 0; i < 18; i++) wr(OFS_TXDATA, 32'(i));
        `CHK("de", 1'h1, line_de)
        ck(OFS_TXLVL, 32'h10);
        rst <= 1'h1;
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        `CHK("txd", 1'h1, txd)
        ck(OFS_CTRL, 32'h3);
        report_and_stop();
    end
endmodule
bind bsp_top bsp_chk bsp_chk_inst (.*);
